/* File: core/address_space_convert_instr.sv */
// conditional address-space conversion: decode, condition gating, register update
// assumes opcode and per-element condition results arrive on clk; compute unit is external
//
// What this block does
// - treats conversion as 48-bit index-modify extension
// - all-ones condition code means unconditional
// - zero compute field means conversion only
// - byte-to-word writes normal-word address
// - word-to-byte writes byte-space address
// - index or base register, same source/destination
// - decode kind, direction and group bits
// - value already in target space copied unchanged
// - compute issued alongside conversion
// - condition gates compute and conversion
// - dual mode computes on both elements
// - each element follows its own condition
// - register update uses OR of outcomes
`timescale 1ns/100ps
module address_space_convert_instr
    import address_convert_op_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic                 instr_valid,
    input  wire logic [INSTR_W-1:0]   instr_word,
    input  wire logic                 dual_pe_mode,
    input  wire logic                 cond_true_x,
    input  wire logic                 cond_true_y,
    output logic                      compute_en_x,
    output logic                      compute_en_y,
    output logic [COMPUTE_W-1:0]      compute_op,
    output reg_write_t                reg_write,
    output logic [ADDR_W-1:0]         index_reg_view,
    output logic [ADDR_W-1:0]         base_reg_view,
    input  wire logic                 view_group,
    input  wire logic [REG_IDX_W-1:0] view_idx,
    input  wire reg_write_t           reg_load
);

    // per group register files: [group][idx]
    logic [ADDR_W-1:0] index_group_one [NUM_REGS];
    logic [ADDR_W-1:0] index_group_two [NUM_REGS];
    logic [ADDR_W-1:0] base_group_one  [NUM_REGS];
    logic [ADDR_W-1:0] base_group_two  [NUM_REGS];

    function automatic logic in_byte_space(input logic [ADDR_W-1:0] a);
        in_byte_space = (a >= BYTE_BASE) && (a <= BYTE_LIMIT);
    endfunction

    function automatic logic in_word_space(input logic [ADDR_W-1:0] a);
        in_word_space = (a >= WORD_BASE) && (a <= WORD_LIMIT);
    endfunction

    conv_op_t          op;
    logic [COND_W-1:0] cond_code;
    logic [COMPUTE_W-1:0] comp_field;
    logic              uncond;
    logic              has_compute;
    logic              pass_x;
    logic              pass_y;
    logic              do_update;
    logic [ADDR_W-1:0] src_value;
    logic [ADDR_W-1:0] result;

    always_comb begin
        op.breg    = instr_word[BREG_BIT];
        op.toby    = instr_word[TOBY_BIT];
        op.group   = instr_word[GROUP_BIT];
        op.idx     = instr_word[REG_LSB +: REG_IDX_W];
        cond_code  = instr_word[COND_LSB +: COND_W];
        comp_field = instr_word[COMPUTE_LSB +: COMPUTE_W];
    end

    assign uncond      = (cond_code == COND_ALWAYS);
    assign has_compute = (comp_field != COMPUTE_NONE);
    // single mode follows x only; dual mode lets each element decide for itself
    assign pass_x      = uncond | cond_true_x;
    assign pass_y      = dual_pe_mode & (uncond | cond_true_y);
    assign do_update   = instr_valid & (pass_x | pass_y);

    // source register is the destination too
    always_comb begin
        case ({op.breg, op.group})
            2'b00:   src_value = index_group_one[op.idx];
            2'b01:   src_value = index_group_two[op.idx];
            2'b10:   src_value = base_group_one[op.idx];
            2'b11:   src_value = base_group_two[op.idx];
            default: src_value = REG_RESET;
        endcase
    end

    // byte address = word window offset times four; other spaces pass through
    always_comb begin
        result = src_value;
        if (op.toby) begin
            if (in_word_space(src_value)) begin
                result = BYTE_BASE + ((src_value - WORD_BASE) << 2);
            end
        end else begin
            if (in_byte_space(src_value)) begin
                result = WORD_BASE + ((src_value - BYTE_BASE) >> 2);
            end
        end
        // already in requested space: result stays the source
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                index_group_one[i] <= REG_RESET;
                index_group_two[i] <= REG_RESET;
                base_group_one[i]  <= REG_RESET;
                base_group_two[i]  <= REG_RESET;
            end
        end else if (clk_en && do_update) begin
            case ({op.breg, op.group})
                2'b00:   index_group_one[op.idx] <= result;
                2'b01:   index_group_two[op.idx] <= result;
                2'b10:   base_group_one[op.idx]  <= result;
                2'b11:   base_group_two[op.idx]  <= result;
                default: ;
            endcase
        end else if (clk_en && reg_load.valid) begin
            // plain register load from other instructions; a conversion in the same cycle wins
            case ({reg_load.is_base, reg_load.group})
                2'b00:   index_group_one[reg_load.idx] <= reg_load.value;
                2'b01:   index_group_two[reg_load.idx] <= reg_load.value;
                2'b10:   base_group_one[reg_load.idx]  <= reg_load.value;
                2'b11:   base_group_two[reg_load.idx]  <= reg_load.value;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_write <= '0;
        end else if (clk_en) begin
            reg_write.valid   <= do_update;
            reg_write.is_base <= op.breg;
            reg_write.group   <= op.group;
            reg_write.idx     <= op.idx;
            reg_write.value   <= result;
        end
    end

    // compute issued in the same cycle as the register write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compute_en_x <= 1'b0;
            compute_en_y <= 1'b0;
            compute_op   <= COMPUTE_NONE;
        end else if (clk_en) begin
            compute_en_x <= instr_valid & has_compute & pass_x;
            compute_en_y <= instr_valid & has_compute & pass_y;
            compute_op   <= comp_field;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            index_reg_view <= REG_RESET;
            base_reg_view  <= REG_RESET;
        end else if (clk_en) begin
            index_reg_view <= view_group ? index_group_two[view_idx] : index_group_one[view_idx];
            base_reg_view  <= view_group ? base_group_two[view_idx] : base_group_one[view_idx];
        end
    end

endmodule

/* File: core/address_convert_op_pkg.sv */
// package for the address-space conversion instruction unit
// assumes a single core clock domain; memory map given as localparams
package address_convert_op_pkg;

    localparam int unsigned INSTR_W   = 48;
    localparam int unsigned COND_W    = 5;
    localparam int unsigned COMPUTE_W = 23;
    localparam int unsigned ADDR_W    = 32;
    localparam int unsigned REG_IDX_W = 3;
    localparam int unsigned NUM_REGS  = 8;

    // opcode field positions
    localparam int unsigned COND_LSB    = 33;
    localparam int unsigned COMPUTE_LSB = 0;
    localparam int unsigned BREG_BIT    = 40;
    localparam int unsigned TOBY_BIT    = 39;
    localparam int unsigned GROUP_BIT   = 38;
    localparam int unsigned REG_LSB     = 23;

    localparam logic [COND_W-1:0]    COND_ALWAYS  = 5'h1f;
    localparam logic [COMPUTE_W-1:0] COMPUTE_NONE = 23'h000000;

    // memory map: byte space window and the normal-word window it mirrors
    localparam logic [ADDR_W-1:0] BYTE_BASE  = 32'h00800000;
    localparam logic [ADDR_W-1:0] BYTE_LIMIT = 32'h00ffffff;
    localparam logic [ADDR_W-1:0] WORD_BASE  = 32'h00200000;
    localparam logic [ADDR_W-1:0] WORD_LIMIT = 32'h003fffff;
    localparam logic [ADDR_W-1:0] REG_RESET  = 32'h00000000;

    typedef struct packed {
        logic                 breg;
        logic                 toby;
        logic                 group;
        logic [REG_IDX_W-1:0] idx;
    } conv_op_t;

    typedef struct packed {
        logic                 valid;
        logic                 is_base;
        logic                 group;
        logic [REG_IDX_W-1:0] idx;
        logic [ADDR_W-1:0]    value;
    } reg_write_t;

endpackage

/* File: testbench/address_convert_op_properties.sv */
// checker on the conversion unit's ports
// assumes one clk domain, async reset_n
`timescale 1ns/100ps
module address_convert_op_properties
    import address_convert_op_pkg::*;
(
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic               clk_en,
    input wire logic               instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic               dual_pe_mode,
    input wire logic               cond_true_x,
    input wire logic               cond_true_y,
    input wire logic               compute_en_x,
    input wire logic               compute_en_y,
    input wire reg_write_t         reg_write
);
    wire t  = clk_en & instr_valid;
    wire al = instr_word[37:33] == COND_ALWAYS;
    wire ox = al | cond_true_x;
    wire oy = dual_pe_mode & (al | cond_true_y);
    wire cz = instr_word[22:0] == COMPUTE_NONE;
    wire vw = (reg_write.value >= WORD_BASE) && (reg_write.value <= WORD_LIMIT);
    wire vb = (reg_write.value >= BYTE_BASE) && (reg_write.value <= BYTE_LIMIT);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_write_taken: assert property (t & (ox | oy) |=> reg_write.valid)
        else $error("write missing");
    a_write_refused: assert property (t & !ox & !oy |=> !reg_write.valid)
        else $error("write despite false condition");
    a_write_idle: assert property (clk_en & !instr_valid |=> !reg_write.valid)
        else $error("write without instruction");
    a_write_target: assert property (t & (ox | oy) |=> reg_write.is_base == $past(instr_word[40])
        && reg_write.group == $past(instr_word[38]) && reg_write.idx == $past(instr_word[25:23]))
        else $error("wrong register written");
    a_compute_x: assert property (t |=> compute_en_x == $past(ox & !cz))
        else $error("compute x wrong");
    a_compute_y: assert property (t |=> compute_en_y == $past(oy & !cz))
        else $error("compute y wrong");
    a_w2b_space: assert property (t & (ox | oy) & instr_word[39] |=> !vw)
        else $error("word to byte left a word address");
    a_b2w_space: assert property (t & (ox | oy) & !instr_word[39] |=> !vb)
        else $error("byte to word left a byte address");
    a_single_mode: assert property (t & !dual_pe_mode |=> !compute_en_y)
        else $error("y compute in single mode");
    c_dual_y_only: cover property (t & !ox & oy);
    c_refused: cover property (t & !ox & !oy);
    c_compute: cover property (t & !cz & ox);
endmodule
bind address_space_convert_instr address_convert_op_properties chk (.clk, .reset_n, .clk_en, .instr_valid,
    .instr_word, .dual_pe_mode, .cond_true_x, .cond_true_y, .compute_en_x, .compute_en_y,
    .reg_write);

/* File: testbench/fetch_model.sv */
// sequencer stand-in: presents one opcode for each go cycle
// assumes go and word_in change just after rising clk
`timescale 1ns/100ps
module fetch_model
    import address_convert_op_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               go,
    input  wire logic [INSTR_W-1:0] word_in,
    output logic                    instr_valid,
    output logic [INSTR_W-1:0]      instr_word
);
    logic [INSTR_W-1:0] last_q = '0;
    // idle bus shows the inverse so a stale opcode is never reused by chance
    always_ff @(posedge clk) if (go) last_q <= word_in;
    assign instr_valid = go;
    assign instr_word  = go ? word_in : ~last_q;
endmodule

/* File: testbench/tb_address_space_convert_instr.sv */
// random conversion instructions checked against a register model
// assumes fetch_model feeds opcodes; checker is bound separately
`timescale 1ns/100ps
module tb_address_space_convert_instr
    import address_convert_op_pkg::*;
;
    logic clk = 0, reset_n = 0, clk_en = 0, go = 0, dual_pe_mode = 0;
    logic cond_true_x = 0, cond_true_y = 0, view_group = 0, instr_valid;
    logic [2:0] view_idx = 0;
    logic [INSTR_W-1:0] w = 0, instr_word, wd;
    logic compute_en_x, compute_en_y, ox, oy, wr;
    reg_write_t rw;
    logic [ADDR_W-1:0] index_reg_view, base_reg_view, ev, lv, rf [2][2][8];
    reg_write_t ld = '0;
    int n_fail = 0, checks = 0, cyc = 0;
    fetch_model feed (.clk, .go, .word_in(w), .instr_valid, .instr_word);
    address_space_convert_instr DUT (.clk, .reset_n, .clk_en, .instr_valid, .instr_word,
        .dual_pe_mode, .cond_true_x, .cond_true_y, .compute_en_x, .compute_en_y,
        .compute_op(), .reg_write(rw), .index_reg_view, .base_reg_view, .view_group, .view_idx,
        .reg_load(ld));
    // start values: inside each window, any 32-bit value, and the WORD_LIMIT or BYTE_BASE edge
    function automatic logic [ADDR_W-1:0] pick(logic [31:0] r, logic [1:0] s);
        if (s == 0) return WORD_BASE + (r % (WORD_LIMIT - WORD_BASE + 1));
        if (s == 1) return BYTE_BASE + (r % (BYTE_LIMIT - BYTE_BASE + 1));
        if (s == 2) return r;
        return r[0] ? WORD_LIMIT : BYTE_BASE;
    endfunction
    function automatic logic [ADDR_W-1:0] conv(logic [ADDR_W-1:0] v, logic toby);
        if (toby && v >= WORD_BASE && v <= WORD_LIMIT) return BYTE_BASE + ((v - WORD_BASE) << 2);
        if (!toby && v >= BYTE_BASE && v <= BYTE_LIMIT) return WORD_BASE + ((v - BYTE_BASE) >> 2);
        return v;
    endfunction
    task automatic chk_val(string n, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever #2 clk = ~clk;
    // ceiling covers 400 instructions of four cycles with ample margin
    always @(posedge clk) if (++cyc == 3000) begin
        n_fail++;
        summarize;
    end
    initial begin
        void'($urandom(32'h75aebbc7));
        foreach (rf[b, g, i]) rf[b][g][i] = REG_RESET;
        repeat (10) @(posedge clk);
        reset_n <= 1;
        clk_en <= 1;
        repeat (400) begin
            wd = 48'({$urandom, $urandom});
            if (wd[0]) wd[37:33] = COND_ALWAYS;
            if (wd[1]) wd[22:0] = COMPUTE_NONE;
            ev = $urandom;
            ox = wd[37:33] == COND_ALWAYS || ev[0];
            oy = ev[2] && (wd[37:33] == COND_ALWAYS || ev[1]);
            wr = ox | oy;
            lv = pick($urandom, 2'($urandom));
            rf[wd[40]][wd[38]][wd[25:23]] = lv;
            @(posedge clk);
            clk_en <= 1'b1;
            ld <= '{1'b1, wd[40], wd[38], wd[25:23], lv};
            @(posedge clk);
            ld.valid <= 1'b0;
            {clk_en, go, w, view_group, view_idx} <= {2'b11, wd, wd[38], wd[25:23]};
            {dual_pe_mode, cond_true_y, cond_true_x} <= ev[2:0];
            ev = conv(rf[wd[40]][wd[38]][wd[25:23]], wd[39]);
            if (wr) rf[wd[40]][wd[38]][wd[25:23]] = ev;
            @(posedge clk);
            go <= 0;
            #1 chk_val("write valid", 32'(wr), 32'(rw.valid));
            chk_val("compute x", 32'(ox && wd[22:0] != 0), 32'(compute_en_x));
            chk_val("compute y", 32'(oy && wd[22:0] != 0), 32'(compute_en_y));
            if (wr) chk_val("write value", ev, rw.value);
            @(posedge clk);
            clk_en <= 1'($urandom);
            #1 chk_val("index view", rf[0][wd[38]][wd[25:23]], index_reg_view);
            chk_val("base view", rf[1][wd[38]][wd[25:23]], base_reg_view);
        end
        $display("random conversion test done");
        summarize;
    end
endmodule
